//--- rtl/tgc_pkg.sv
/*
  Constants and carrier types for the transmit gain-control register bank.
  Assumes a serial-port decoder on the same clock that turns frames into
  single-cycle register write and read requests.
*/
// How it works
// R1 - two-bit source select: 00 internal, 10 analog
// R2 - 12-bit attenuator code from two registers
// R3 - upper part staged, applied on lower write
// R4 - host writes upper register before lower one; bench read-back pass writes lower first
// R5 - 5-bit step field, one copy per mode
// R6 - mode pin picks the applied setting set
// R7 - pin low uses mode0 set, high mode1
// R8 - system ties both identity straps low
// R9 - upper bits 3:0 become code bits 11:8
package tgc_pkg;

  // ********************************************************
  // register offsets (9-bit register address)
  // ********************************************************
  localparam logic [8:0] TGC_OFS_STEP_MODE0 = 9'h102;
  localparam logic [8:0] TGC_OFS_CODE_LOW   = 9'h103;
  localparam logic [8:0] TGC_OFS_CODE_HIGH  = 9'h104;
  localparam logic [8:0] TGC_OFS_SRC_SEL    = 9'h105;
  localparam logic [8:0] TGC_OFS_STEP_MODE1 = 9'h112;

  // ********************************************************
  // field layout and reset values
  // ********************************************************
  localparam int         TGC_STEP_W      = 5;
  localparam int         TGC_CODE_W      = 12;
  localparam int         TGC_HIGH_W      = 4;
  localparam logic [1:0] TGC_SRC_DAC     = 2'h0;
  localparam logic [1:0] TGC_SRC_ANALOG  = 2'h2;
  localparam logic [7:0] TGC_RST_BYTE    = 8'h00;
  localparam logic [7:0] TGC_RST_SRC     = 8'h00;
  localparam logic [7:0] TGC_RD_UNMAPPED = 8'h00;

  // ********************************************************
  // carrier types
  // ********************************************************
  typedef struct packed {
    logic       en;
    logic [8:0] addr;
    logic [7:0] data;
  } tgc_wr_t;

  typedef struct packed {
    logic       en;
    logic [8:0] addr;
  } tgc_rd_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } tgc_rsp_t;

endpackage

//--- rtl/tgc_regs.sv
/*
  Transmit gain-control register bank: attenuator source select,
  double-buffered 12-bit attenuator code and two step-attenuator copies
  picked by the mode pin.
  Assumes requests come from same-clock logic; the mode pin is async.
*/
`timescale 1ns/1ps
module tgc_regs (
  // clock and reset
  input  wire logic                         ref_clk,
  input  wire logic                         nrst,
  // register requests from the serial-port decoder
  input  wire tgc_pkg::tgc_wr_t             wr_req,
  input  wire tgc_pkg::tgc_rd_t             rd_req,
  output tgc_pkg::tgc_rsp_t                 rd_rsp,
  // mode pin, asynchronous
  input  wire logic                         tx_mode_select_pin,
  // attenuator controls
  output logic [tgc_pkg::TGC_CODE_W-1:0]    attenuator_dac_code,
  output logic                              dac_drive_en,
  output logic                              analog_drive_en,
  output logic [tgc_pkg::TGC_STEP_W-1:0]    step_attenuator,
  output logic                              active_mode
);
  import tgc_pkg::*;

  // ********************************************************
  // reset release and mode pin synchroniser
  // ********************************************************
  logic rst_m_q, rst_s_q, rst_n;
  logic mode_m_q, mode_s_q;

  // release is synchronous so no flop sees a runt reset edge
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rst_m_q <= 1'b0;
      rst_s_q <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_s_q <= rst_m_q;
    end
  end
  assign rst_n = rst_s_q;

  // two stages; only mode_s_q is read by logic
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_m_q <= 1'b0;
      mode_s_q <= 1'b0;
    end else begin
      mode_m_q <= tx_mode_select_pin;
      mode_s_q <= mode_m_q;
    end
  end

  // ********************************************************
  // register storage
  // ********************************************************
  logic [7:0] step0_q, step1_q, low_q, high_q, src_q;
  logic       wr_low;

  assign wr_low = wr_req.en && (wr_req.addr == TGC_OFS_CODE_LOW);

  // plain byte registers; upper code byte is only a staging copy
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      step0_q <= TGC_RST_BYTE;
      step1_q <= TGC_RST_BYTE;
      low_q   <= TGC_RST_BYTE;
      high_q  <= TGC_RST_BYTE;
      src_q   <= TGC_RST_SRC;
    end else if (wr_req.en) begin
      case (wr_req.addr)
        TGC_OFS_STEP_MODE0: step0_q <= wr_req.data; // R5
        TGC_OFS_STEP_MODE1: step1_q <= wr_req.data; // R5
        TGC_OFS_CODE_LOW:   low_q   <= wr_req.data;
        TGC_OFS_CODE_HIGH:  high_q  <= wr_req.data; // R3
        TGC_OFS_SRC_SEL:    src_q   <= wr_req.data;
        default: ;
      endcase
    end
  end

  // ********************************************************
  // attenuator code, applied as one 12-bit word
  // ********************************************************
  // staged upper nibble joins the new low byte; a host that writes the
  // low byte first gets the previous upper nibble applied
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      attenuator_dac_code <= '0;
    end else if (wr_low) begin
      attenuator_dac_code <= {high_q[TGC_HIGH_W-1:0], wr_req.data}; // R2 R3 R9
    end
  end

  // source select: undefined codes drive neither source
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dac_drive_en    <= 1'b0;
      analog_drive_en <= 1'b0;
    end else begin
      dac_drive_en    <= (src_q[1:0] == TGC_SRC_DAC);    // R1
      analog_drive_en <= (src_q[1:0] == TGC_SRC_ANALOG); // R1
    end
  end

  // ********************************************************
  // mode-selected step attenuation
  // ********************************************************
  // no serial-port involvement, only the synchroniser and this flop
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      step_attenuator <= '0;
      active_mode     <= 1'b0;
    end else begin
      step_attenuator <= mode_s_q ? step1_q[TGC_STEP_W-1:0]
                                  : step0_q[TGC_STEP_W-1:0]; // R6 R7
      active_mode     <= mode_s_q; // R6
    end
  end

  // ********************************************************
  // read path, answer one cycle after the request
  // ********************************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_rsp <= '0;
    end else begin
      rd_rsp.valid <= rd_req.en;
      case (rd_req.addr)
        TGC_OFS_STEP_MODE0: rd_rsp.data <= step0_q;
        TGC_OFS_STEP_MODE1: rd_rsp.data <= step1_q;
        TGC_OFS_CODE_LOW:   rd_rsp.data <= low_q;
        TGC_OFS_CODE_HIGH:  rd_rsp.data <= high_q;
        TGC_OFS_SRC_SEL:    rd_rsp.data <= src_q;
        default:            rd_rsp.data <= TGC_RD_UNMAPPED;
      endcase
    end
  end

  // ********************************************************
  // checks
  // ********************************************************
  sequence high_only_s;
    wr_req.en && (wr_req.addr == TGC_OFS_CODE_HIGH);
  endsequence

  sequence low_write_s;
    wr_low;
  endsequence

  // analog path enable follows the stored select one edge later
  src_analog_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R1
    analog_drive_en == ($past(src_q[1:0]) == TGC_SRC_ANALOG))
    else $error("analog drive does not follow source select");

  // dac path enable; the edge after release still shows reset zeros
  src_dac_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R1
    dac_drive_en == ($past(src_q[1:0]) == TGC_SRC_DAC) || !$past(rst_n))
    else $error("dac drive does not follow source select");

  // whole code from the staged nibble and the new low byte
  code_apply_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R9
    low_write_s |=> attenuator_dac_code ==
      {$past(high_q[3:0]), $past(wr_req.data)})
    else $error("dac code not assembled from staged and low byte");

  // an upper byte write alone must leave the applied code alone
  no_partial_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R3
    high_only_s |=> $stable(attenuator_dac_code))
    else $error("dac code changed on upper byte write");

  // nothing but a low byte write may move the applied code
  code_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R3
    !wr_low |=> $stable(attenuator_dac_code))
    else $error("dac code moved without a low byte write");

  // the staged byte holds exactly what the host wrote
  high_store_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R3
    high_only_s |=> high_q == $past(wr_req.data))
    else $error("upper byte not staged as written");

  // staged nibble survives an idle edge before the low write
  staged_pair_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R3
    high_only_s ##1 (!wr_req.en)[*1] ##1 low_write_s |=>
      attenuator_dac_code[11:8] == $past(wr_req.data[3:0], 3))
    else $error("staged upper nibble lost before low write");

  // rising mode picks the mode1 copy at the next edge
  mode_pick_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R7
    $rose(mode_s_q) && $stable(step1_q) |=>
      step_attenuator == $past(step1_q[4:0]) && active_mode)
    else $error("mode high did not apply mode1 step");

  // mode high always applies the mode1 copy
  step_mode1_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R7
    mode_s_q |=> step_attenuator == $past(step1_q[TGC_STEP_W-1:0]))
    else $error("mode1 step copy not applied");

  // mode low always applies the mode0 copy
  step_mode0_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R7
    !mode_s_q |=> step_attenuator == $past(step0_q[TGC_STEP_W-1:0]))
    else $error("mode0 step copy not applied");

  // reported mode is the synchronised pin, one edge later
  mode_follow_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R6
    active_mode == $past(mode_s_q))
    else $error("active mode does not follow synchronised pin");

  // pin low long enough must leave mode0 in use
  pin_latency_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R6
    (tx_mode_select_pin == 1'b0)[*4] |-> !active_mode)
    else $error("mode did not follow pin within three cycles");

  // a mode0 write reaches the applied step two edges on
  step_field_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R5
    wr_req.en && wr_req.addr == TGC_OFS_STEP_MODE0 && !mode_s_q
      ##1 !mode_s_q && !(wr_req.en && wr_req.addr == TGC_OFS_STEP_MODE0)
      |=> step_attenuator == $past(wr_req.data[4:0], 2))
    else $error("mode0 step field not applied");

  // read answer pulses exactly one edge after each request
  rd_valid_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rd_rsp.valid == $past(rd_req.en))
    else $error("read answer not one edge after request");

endmodule

//--- testbench/tgc_host_model.sv
/*
  host-side model: register writes and reads, and the mode pin.
  assumes tasks are called just after a rising edge of ref_clk.
*/
`timescale 1ns/1ps
module tgc_host_model (
  // clock
  input  wire logic              ref_clk,
  // requests to the bank
  output tgc_pkg::tgc_wr_t       wr_req,
  output tgc_pkg::tgc_rd_t       rd_req,
  input  wire tgc_pkg::tgc_rsp_t rd_rsp,
  // mode pin, the bench sets it
  output logic                   tx_mode_select_pin
);
  import tgc_pkg::*;
  // single-device use: both identity straps held low
  logic chip_id_strap_low;
  logic chip_id_strap_high;
  assign chip_id_strap_low  = 1'b0;
  assign chip_id_strap_high = 1'b0;
  // idle at time zero
  initial begin
    wr_req = '0;
    rd_req = '0;
    tx_mode_select_pin = 1'b0;
  end
  // one write; idle edge after so calls never collide
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    wr_req = '{1'b1, a, d};
    @(posedge ref_clk);
    #1 wr_req = '{1'b0, ~a, ~d};
    @(posedge ref_clk);
    #1;
  endtask
  // one read; answer taken just after the edge that takes the request
  task automatic rd(input logic [8:0] a, output tgc_rsp_t r);
    rd_req = '{1'b1, a};
    @(posedge ref_clk);
    #1 rd_req = '{1'b0, ~a};
    r = rd_rsp;
    @(posedge ref_clk);
    #1;
  endtask
  // mode pin level; call just after a rising edge
  task automatic set_mode(input logic m);
    tx_mode_select_pin = m;
  endtask
endmodule

//--- testbench/tgc_regs_tb_top.sv
/*
  self-checking bench for the gain-control register bank.
  assumes the host model drives all requests and the mode pin.
*/
`timescale 1ns/1ps
module tgc_regs_tb_top;
  import tgc_pkg::*;
  logic        ref_clk, nrst, dac_drive_en, analog_drive_en, active_mode;
  tgc_wr_t     wr_req;
  tgc_rd_t     rd_req;
  tgc_rsp_t    rd_rsp, r;
  logic [11:0] attenuator_dac_code, c, p;
  logic [4:0]  step_attenuator;
  logic        tx_mode_select_pin;
  logic [7:0]  d, s0, s1;
  logic [8:0]  ofs [5];
  int          n_mismatch, check_count, cyc;

  tgc_regs dut (.ref_clk(ref_clk), .nrst(nrst), .wr_req(wr_req),
    .rd_req(rd_req), .rd_rsp(rd_rsp),
    .tx_mode_select_pin(tx_mode_select_pin),
    .attenuator_dac_code(attenuator_dac_code),
    .dac_drive_en(dac_drive_en), .analog_drive_en(analog_drive_en),
    .step_attenuator(step_attenuator), .active_mode(active_mode));
  tgc_host_model host (.ref_clk(ref_clk), .wr_req(wr_req),
    .rd_req(rd_req), .rd_rsp(rd_rsp),
    .tx_mode_select_pin(tx_mode_select_pin));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // hang guard, far above the roughly 150 cycles needed
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  function automatic logic [11:0] exp_code(logic [7:0] h, logic [7:0] l);
    return {h[3:0], l};
  endfunction
  function automatic logic [4:0] exp_step(logic m, logic [7:0] a, b);
    return m ? b[4:0] : a[4:0];
  endfunction
  task automatic chk(input logic [15:0] got, exp, input string m);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // mode pin passes a synchroniser, so allow four edges
  task automatic settle();
    repeat (4) @(posedge ref_clk);
    #1;
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    nrst = 1'b0;
    ofs = '{TGC_OFS_STEP_MODE0, TGC_OFS_CODE_LOW, TGC_OFS_CODE_HIGH,
            TGC_OFS_SRC_SEL, TGC_OFS_STEP_MODE1};
    void'($urandom(58470));
    repeat (5) @(posedge ref_clk);
    #1 nrst = 1'b1;
    settle();
    chk(attenuator_dac_code, exp_code(TGC_RST_BYTE, TGC_RST_BYTE),
        "reset code");
    // reset values, then random read-back of every register
    foreach (ofs[i]) begin
      host.rd(ofs[i], r);
      chk({r.valid, r.data}, {1'b1, TGC_RST_BYTE}, "reset");
      d = 8'($urandom);
      host.wr(ofs[i], d);
      host.rd(ofs[i], r);
      chk({r.valid, r.data}, {1'b1, d}, "readback");
      // upper part is still at reset when the low byte lands here
      if (ofs[i] == TGC_OFS_CODE_LOW) begin
        p = exp_code(TGC_RST_BYTE, d);
      end
    end
    // unmapped place: write ignored, read gives the fixed byte
    host.wr(9'h106, 8'hA5);
    host.rd(9'h106, r);
    chk({r.valid, r.data}, {1'b1, TGC_RD_UNMAPPED}, "unmapped");
    // every source code
    for (int i = 0; i < 4; i++) begin
      host.wr(TGC_OFS_SRC_SEL, 8'(i));
      settle();
      chk({analog_drive_en, dac_drive_en}, {i == 2, i == 0}, "src");
    end
    // staged upper part must not reach the code alone; the code is a
    // flop loaded at the write edge, so no settling is needed before
    // the look, and the low write follows after one idle edge
    for (int k = 0; k < 4; k++) begin
      c = (k == 0) ? 12'hFFF : 12'($urandom);
      d = {4'($urandom), c[11:8]};
      host.wr(TGC_OFS_CODE_HIGH, d);
      chk(attenuator_dac_code, p, "staged");
      host.wr(TGC_OFS_CODE_LOW, c[7:0]);
      settle();
      chk(attenuator_dac_code, exp_code(d, c[7:0]), "code");
      p = exp_code(d, c[7:0]);
    end
    // both step copies, pin switches between them
    for (int k = 0; k < 4; k++) begin
      s0 = 8'($urandom);
      s1 = (k == 0) ? 8'h1F : 8'($urandom);
      host.wr(TGC_OFS_STEP_MODE0, s0);
      host.wr(TGC_OFS_STEP_MODE1, s1);
      for (int m = 0; m < 2; m++) begin
        host.set_mode(m[0]);
        settle();
        chk({active_mode, step_attenuator},
            {m[0], exp_step(m[0], s0, s1)}, "step");
      end
    end
    print_verdict();
  end
endmodule
